//--- hdl/scd_device.sv
// Card interface end: decodes the command byte from the serial link and
// drives supply code, card clock, reset and direct contact levels.
// Assumes all link and card pins are asynchronous to clk_sys (40 MHz) and
// that the link clock is much slower than clk_sys.
//
// Notes on behaviour
// - Byte is three mode bits, five data bits.
// - Only traffic with chip select low counts.
// - Card reset follows bit 4 at once.
// - Host sends bit 4 low for configuration.
// - Bits 1..0 pick card supply code.
// - Bits 3..2 pick card clock divide.
// - Synchronous mode drives four contacts directly.
// - Config codes 0/1 set presence polarity.
// - Config codes 2/3 set serial edge mode.
// - Slot modes answer only on strap match.
// - External mode needs a dedicated chip select.
// - Synchronous mode needs a dedicated chip select.
// - Reserved mode takes no configuration action.
// - Config codes 4/5 set card clock edges.
// - Read-back shifts on edge chosen by mode.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module scd_device
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial link
    scd_link_if.dev link,
    // Card clock source and presence switch
    input wire logic card_clk_in,
    input wire logic card_present_in,
    // Card supply, clock and reset
    output logic [1:0] card_supply,
    output logic card_clock_out,
    output logic card_reset_out,
    // Two-way card contacts
    input wire logic card_data_line_i,
    output logic card_data_line_o,
    output logic card_data_line_oe,
    input wire logic aux_contact_four_strap0_i,
    output logic aux_contact_four_strap0_o,
    output logic aux_contact_four_strap0_oe,
    input wire logic aux_contact_eight_strap1_i,
    output logic aux_contact_eight_strap1_o,
    output logic aux_contact_eight_strap1_oe,
    // Configuration state
    output logic card_presence_polarity,
    output logic special_edge_mode,
    output logic slow_edge_select,
    output logic fast_edge_select
);
    // ----------------------------------------------------------------
    // Input synchronisation and edges
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync_bus;
    logic sclk_s, cs_n_s, mosi_s, cclk_s, pres_s, cdat_s, c4_s, c8_s;
    logic sclk_prev_q, cs_n_prev_q, cclk_prev_q;
    logic sclk_rise, sclk_fall, cs_fall, cclk_rise;

    scd_sync3 #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({aux_contact_eight_strap1_i, aux_contact_four_strap0_i, card_data_line_i,
                   card_present_in, card_clk_in, link.mosi, link.cs_n, link.sclk}),
        .sync_out(sync_bus)
    );
    assign {c8_s, c4_s, cdat_s, pres_s, cclk_s, mosi_s, cs_n_s, sclk_s} = sync_bus;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_prev_q <= 1'h0;
            cs_n_prev_q <= 1'h1;
            cclk_prev_q <= 1'h0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            cs_n_prev_q <= cs_n_s;
            cclk_prev_q <= cclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign cs_fall = ~cs_n_s & cs_n_prev_q;
    assign cclk_rise = cclk_s & ~cclk_prev_q;

    // ----------------------------------------------------------------
    // Command byte reception
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] byte_in;
    logic [2:0] mode_in;
    logic [1:0] strap_q;
    logic sync_q;
    logic bit_take, byte_done, rst_take;

    function automatic logic addressed(input logic [2:0] mode, input logic [1:0] strap);
        // Modes 100 to 111 sit on a dedicated select and always answer
        addressed = mode[2] | (mode[1:0] == strap);
    endfunction : addressed

    assign byte_in = {shift_q[6:0], mosi_s};
    assign mode_in = byte_in[7:5];
    assign bit_take = sclk_rise & ~cs_n_s & (bit_cnt_q != BIT_FULL);
    assign byte_done = bit_take & (bit_cnt_q == BIT_LAST);
    assign rst_take = bit_take & (bit_cnt_q == BIT_RST_POS) & addressed(shift_q[2:0], strap_q);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end
        else if (cs_n_s)
            bit_cnt_q <= 4'h0;
        else if (bit_take)
        begin
            shift_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Straps are only read while the contacts are inputs and the link is idle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            strap_q <= 2'h0;
        else if (!sync_q && cs_n_s)
            strap_q <= {c8_s, c4_s};
    end

    // Reset follows bit 4 as it arrives, before the byte is complete
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            card_reset_out <= RST_CARD_RESET;
        else if (rst_take)
            card_reset_out <= mosi_s;
    end

    // ----------------------------------------------------------------
    // Supply, clock and direct contact settings
    // ----------------------------------------------------------------
    logic [1:0] supply_q;
    logic [1:0] clk_sel_q;
    logic [3:0] direct_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            supply_q <= RST_SUPPLY;
            clk_sel_q <= RST_CLK_SEL;
            direct_q <= RST_DIRECT;
            sync_q <= 1'h0;
        end
        else if (byte_done && addressed(mode_in, strap_q))
        begin
            if (mode_in == MODE_SYNC)
            begin
                sync_q <= 1'h1;
                direct_q <= byte_in[3:0];
            end
            else if (!mode_in[2] || mode_in == MODE_EXT)
            begin
                supply_q <= byte_in[1:0];
                clk_sel_q <= byte_in[3:2];
                sync_q <= 1'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration register; undefined codes and mode 111 change nothing
    // ----------------------------------------------------------------
    logic polarity_q, special_q, slow_q, fast_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            polarity_q <= RST_POLARITY;
            special_q <= RST_SPECIAL;
            slow_q <= RST_SLOW;
            fast_q <= ~RST_SLOW;
        end
        else if (byte_done && mode_in == MODE_CFG)
        begin
            unique case (byte_in[4:0])
                CFG_DET_NO: polarity_q <= 1'h0;
                CFG_DET_NC: polarity_q <= 1'h1;
                CFG_SPECIAL: special_q <= 1'h1;
                CFG_NORMAL: special_q <= 1'h0;
                CFG_SLOW:
                begin
                    slow_q <= 1'h1;
                    fast_q <= 1'h0;
                end
                CFG_FAST:
                begin
                    slow_q <= 1'h0;
                    fast_q <= 1'h1;
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Card clock generation from the sampled input clock
    // ----------------------------------------------------------------
    // Undivided output follows the sampled input, so it carries the
    // synchroniser delay; the input must stay well below clk_sys / 2.
    logic cclk_out_q, div_half_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cclk_out_q <= 1'h0;
            div_half_q <= 1'h0;
        end
        else
        begin
            if (cclk_rise)
                div_half_q <= ~div_half_q;
            if (sync_q)
                cclk_out_q <= direct_q[3];
            else
            begin
                unique case (clk_sel_q)
                    CLK_LOW: cclk_out_q <= 1'h0;
                    CLK_DIV1: cclk_out_q <= cclk_s;
                    CLK_DIV2: cclk_out_q <= cclk_out_q ^ cclk_rise;
                    CLK_DIV4: cclk_out_q <= cclk_out_q ^ (cclk_rise & div_half_q);
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Read-back shifter
    // ----------------------------------------------------------------
    // Every device on a shared select drives the line while it is low,
    // as the shared bank gives no address before the first bit.
    logic [7:0] rb_q;
    logic [7:0] rb_byte;
    logic miso_q, miso_oe_q, rb_shift;

    assign rb_byte = {3'h0, pres_s, cdat_s, c4_s, c8_s, |supply_q};
    assign rb_shift = ~cs_n_s & (special_q ? sclk_rise : sclk_fall);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rb_q <= 8'h00;
            miso_q <= 1'h0;
            miso_oe_q <= 1'h0;
        end
        else
        begin
            miso_oe_q <= ~cs_n_s;
            if (cs_fall)
            begin
                rb_q <= special_q ? rb_byte : {rb_byte[6:0], 1'h0};
                miso_q <= special_q ? 1'h0 : rb_byte[7];
            end
            else if (rb_shift)
            begin
                rb_q <= {rb_q[6:0], 1'h0};
                miso_q <= rb_q[7];
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.miso = miso_q;
    assign link.miso_oe = miso_oe_q;
    assign card_supply = supply_q;
    assign card_clock_out = cclk_out_q;
    assign card_data_line_o = direct_q[2];
    assign card_data_line_oe = sync_q;
    assign aux_contact_four_strap0_o = direct_q[1];
    assign aux_contact_four_strap0_oe = sync_q;
    assign aux_contact_eight_strap1_o = direct_q[0];
    assign aux_contact_eight_strap1_oe = sync_q;
    assign card_presence_polarity = polarity_q;
    assign special_edge_mode = special_q;
    assign slow_edge_select = slow_q;
    assign fast_edge_select = fast_q;
endmodule : scd_device
`default_nettype wire

//--- hdl/scd_host.sv
// Host controller end: takes command bytes over AHB-Lite and shifts
// them out on the serial link, capturing the read-back byte.
// Assumes one device on a dedicated select and a zero-wait AHB slave slot.
`timescale 1ns/10ps
`default_nettype none
module scd_host
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial link
    scd_link_if.host link
);
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    scd_host_state_t state_q;
    logic ap_wr_q, special_q, start, ap_take;
    logic [7:0] ap_addr_q, half_q, tx_q, rx_q;
    logic [7:0] tx_byte;
    logic [31:0] hrdata_q;

    assign ap_take = hsel & hready & htrans[1];
    assign start = ap_wr_q & (ap_addr_q == HOST_TX_OFS) & (state_q == HS_IDLE);
    // Configuration commands go out with bit 4 low to keep card reset low
    assign tx_byte = (hwdata[7:5] == MODE_CFG) ? (hwdata[7:0] & 8'hEF) : hwdata[7:0];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ap_wr_q <= 1'h0;
            ap_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else if (hready)
        begin
            ap_wr_q <= ap_take & hwrite;
            ap_addr_q <= haddr[7:0];
            if (ap_take && !hwrite)
            begin
                unique case (haddr[7:0])
                    HOST_TX_OFS: hrdata_q <= {24'h00_0000, tx_q};
                    HOST_STAT_OFS: hrdata_q <= {16'h0000, rx_q, 7'h00, state_q != HS_IDLE};
                    HOST_CFG_OFS: hrdata_q <= {23'h00_0000, special_q, half_q};
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // A byte written while busy is dropped
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_q <= 8'h00;
            half_q <= HALF_RST;
            special_q <= RST_SPECIAL;
        end
        else
        begin
            if (start)
                tx_q <= tx_byte;
            if (ap_wr_q && ap_addr_q == HOST_CFG_OFS)
            begin
                half_q <= hwdata[7:0];
                special_q <= hwdata[CFG_SPECIAL_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
        else
        begin
            hreadyout <= 1'h1;
            hresp <= 1'h0;
        end
    end
    assign hrdata = hrdata_q;

    // ----------------------------------------------------------------
    // Half-period divider; one-cycle tick while a transfer runs
    // ----------------------------------------------------------------
    logic [7:0] tmr_q;
    logic tick;

    assign tick = (state_q != HS_IDLE) & (tmr_q == 8'h00);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            tmr_q <= 8'h00;
        else if (state_q == HS_IDLE || tick)
            tmr_q <= half_q - 8'h01;
        else
            tmr_q <= tmr_q - 8'h01;
    end

    // ----------------------------------------------------------------
    // Link sequencer: MSB first, data changes on falling sclk
    // ----------------------------------------------------------------
    logic cs_n_q, sclk_q, mosi_q;
    logic [7:0] sh_q, rxsh_q;
    logic [2:0] cnt_q;
    logic [7:0] rx_next;

    assign rx_next = {rxsh_q[6:0], link.miso_line};

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= HS_IDLE;
            cs_n_q <= 1'h1;
            sclk_q <= 1'h0;
            mosi_q <= 1'h0;
            sh_q <= 8'h00;
            rxsh_q <= 8'h00;
            rx_q <= 8'h00;
            cnt_q <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                HS_IDLE:
                    if (start)
                    begin
                        cs_n_q <= 1'h0;
                        sh_q <= tx_byte;
                        mosi_q <= tx_byte[7];
                        cnt_q <= 3'h0;
                        state_q <= HS_SETUP;
                    end
                HS_SETUP:
                    if (tick)
                    begin
                        sclk_q <= 1'h1;
                        if (!special_q)
                            rxsh_q <= rx_next;
                        state_q <= HS_SHIFT;
                    end
                HS_SHIFT:
                    if (tick && sclk_q)
                    begin
                        sclk_q <= 1'h0;
                        if (special_q)
                            rxsh_q <= rx_next;
                        if (cnt_q == 3'h7)
                            state_q <= HS_HOLD;
                        else
                        begin
                            cnt_q <= cnt_q + 3'h1;
                            sh_q <= {sh_q[6:0], 1'h0};
                            mosi_q <= sh_q[6];
                        end
                    end
                    else if (tick)
                    begin
                        sclk_q <= 1'h1;
                        if (!special_q)
                            rxsh_q <= rx_next;
                    end
                HS_HOLD:
                    if (tick && !cs_n_q)
                    begin
                        cs_n_q <= 1'h1;
                        rx_q <= rxsh_q;
                    end
                    else if (tick)
                        state_q <= HS_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;
endmodule : scd_host
`default_nettype wire

//--- hdl/scd_link_if.sv
// Serial command link between the host controller and the card device.
// Assumes one host and one device; the read-back line idles high.
`timescale 1ns/10ps
`default_nettype none
interface scd_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Pull-up level when the device releases the read-back line
    assign miso_line = miso_oe ? miso : 1'h1;

    modport host (output cs_n, output sclk, output mosi, input miso_line);
    modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
endinterface : scd_link_if
`default_nettype wire

//--- hdl/scd_pkg.sv
// Shared constants and types for the card command link: mode codes,
// configuration codes, reset values and the host register map.
// Assumes both ends and the bench import it whole.
package scd_pkg;
    // ----------------------------------------------------------------
    // Command byte layout
    // ----------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam logic [2:0] MODE_EXT = 3'h4;
    localparam logic [2:0] MODE_CFG = 3'h5;
    localparam logic [2:0] MODE_SYNC = 3'h6;
    localparam logic [2:0] MODE_RSV = 3'h7;
    localparam logic [3:0] BIT_RST_POS = 4'h3;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FULL = 4'h8;
    // ----------------------------------------------------------------
    // Data field codes under the configuration mode
    // ----------------------------------------------------------------
    localparam logic [4:0] CFG_DET_NO = 5'h00;
    localparam logic [4:0] CFG_DET_NC = 5'h01;
    localparam logic [4:0] CFG_SPECIAL = 5'h02;
    localparam logic [4:0] CFG_NORMAL = 5'h03;
    localparam logic [4:0] CFG_SLOW = 5'h04;
    localparam logic [4:0] CFG_FAST = 5'h05;
    // ----------------------------------------------------------------
    // Card clock selections and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] CLK_LOW = 2'h0;
    localparam logic [1:0] CLK_DIV1 = 2'h1;
    localparam logic [1:0] CLK_DIV2 = 2'h2;
    localparam logic [1:0] CLK_DIV4 = 2'h3;
    localparam logic [1:0] RST_SUPPLY = 2'h0;
    localparam logic [1:0] RST_CLK_SEL = 2'h0;
    localparam logic [3:0] RST_DIRECT = 4'h0;
    localparam logic RST_CARD_RESET = 1'h0;
    localparam logic RST_POLARITY = 1'h0;
    localparam logic RST_SPECIAL = 1'h0;
    localparam logic RST_SLOW = 1'h0;
    // Sync order: strap1, strap0, data, presence, card clk, mosi, cs_n, sclk
    localparam int SYNC_W = 8;
    localparam logic [7:0] SYNC_RST = 8'h02;
    // ----------------------------------------------------------------
    // Host register map
    // ----------------------------------------------------------------
    localparam logic [7:0] HOST_TX_OFS = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam logic [7:0] HOST_CFG_OFS = 8'h08;
    localparam logic [7:0] HALF_RST = 8'h08;
    localparam int CFG_SPECIAL_BIT = 8;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_SETUP = 2'h1,
        HS_SHIFT = 2'h3,
        HS_HOLD = 2'h2
    } scd_host_state_t;
endpackage : scd_pkg

//--- hdl/scd_sync3.sv
// Three-stage input synchroniser with agreement filter, one lane a bit.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module scd_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Lanes
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A lane moves only once stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sync_out <= RST_VAL;
        else
            sync_out <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & sync_out);
    end
endmodule : scd_sync3
`default_nettype wire

//--- test/scd_checker.sv
// Wire checks on the serial command link between host and device ends.
// Assumes the bench places it beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module scd_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_oe
);
    logic sclk_q;
    logic [3:0] cnt_q;
    logic [2:0] mode_q;

    // Rising serial clocks inside one select and the last three bits seen
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'h0;
            cnt_q <= 4'h0;
            mode_q <= 3'h0;
        end
        else
        begin
            sclk_q <= sclk;
            if (cs_n)
                cnt_q <= 4'h0;
            else if (sclk && !sclk_q)
            begin
                cnt_q <= cnt_q + 4'h1;
                mode_q <= {mode_q[1:0], mosi};
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved while serial clock high");
    a_eight_bits: assert property ($rose(cs_n) |-> cnt_q == 4'h8)
        else $error("select released after a byte not of eight clocks");
    a_half_min: assert property ($rose(sclk) |-> sclk[*6])
        else $error("serial clock high phase too short");
    a_gap_min: assert property ($rose(cs_n) |-> cs_n[*7])
        else $error("select gap too short");
    a_cfg_rst_low: assert property (sclk && !sclk_q && cnt_q == 4'h3 && mode_q == 3'h5
        |-> !mosi)
        else $error("configuration byte sent with reset bit high");
    a_oe_selected: assert property ($rose(miso_oe) |-> !cs_n)
        else $error("read-back driven while deselected");
    a_oe_release: assert property (cs_n [*8] |-> !miso_oe)
        else $error("read-back line held after deselect");
endmodule : scd_checker
`default_nettype wire

//--- test/smart_card_spi_command_decoder_bench.sv
// Bench for both link ends: commands go in over AHB-Lite, card pins are compared.
// Assumes straps read slot 2 and the data contact has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module smart_card_spi_command_decoder_bench
    import scd_pkg::*;
;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [2:0] ck_q = 3'h0;
    logic [1:0] card_supply;
    logic card_clock_out, card_reset_out, d_o, d_oe, c4_o, c4_oe, c8_o, c8_oe;
    logic pol, spec, slow, fast;
    int n_fail = 0;
    int checked = 0;
    int n_clk = 0;
    logic [7:0] cmd_l [13] = '{8'h41, 8'h13, 8'h93, 8'hB1, 8'hA2, 8'hA4, 8'hA5, 8'hA3,
        8'hA0, 8'hF7, 8'hDA, 8'hC5, 8'h80};
    logic [11:0] exp_l [13] = '{12'h420, 12'h420, 12'hE20, 12'hD20, 12'hDA0, 12'hDC0,
        12'hDA0, 12'hD20, 12'hC20, 12'hE20, 12'hE35, 12'hC3A, 12'h020};
    // Undriven contact outputs are masked so stale levels do not count
    wire logic [11:0] vec = {card_supply, card_reset_out, pol, spec, slow, fast, d_oe,
        d_o & d_oe, c4_o & c4_oe, c8_o & c8_oe, card_clock_out};

    scd_link_if link ();
    scd_host u_scd_host (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .link(link.host));
    scd_device u_scd_device (.clk_sys, .rst_n, .link(link.dev), .card_clk_in(ck_q[2]),
        .card_present_in(1'h1), .card_supply, .card_clock_out, .card_reset_out,
        .card_data_line_i(d_oe ? d_o : 1'h1), .card_data_line_o(d_o), .card_data_line_oe(d_oe),
        .aux_contact_four_strap0_i(c4_oe ? c4_o : 1'h0), .aux_contact_four_strap0_o(c4_o),
        .aux_contact_four_strap0_oe(c4_oe), .aux_contact_eight_strap1_i(c8_oe ? c8_o : 1'h1),
        .aux_contact_eight_strap1_o(c8_o), .aux_contact_eight_strap1_oe(c8_oe),
        .card_presence_polarity(pol), .special_edge_mode(spec), .slow_edge_select(slow),
        .fast_edge_select(fast));
    scd_checker u_scd_checker (.clk_sys, .rst_n, .cs_n(link.cs_n), .sclk(link.sclk),
        .mosi(link.mosi), .miso_oe(link.miso_oe));

    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) ck_q <= ck_q + 3'h1;
    always @(posedge card_clock_out) n_clk++;

    task automatic stop_test;
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'h1)
        begin
            n++;
            if (n > 50)
            begin
                n_fail++;
                stop_test;
            end
            @(posedge clk_sys);
        end
    endtask : wait_ready

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        r = hrdata;
    endtask : ahb

    // Read status twice at least before trusting busy
    task automatic send(input logic [7:0] c);
        logic [31:0] r;
        int n;
        ahb(1'h1, HOST_TX_OFS, {24'h0, c}, r);
        n = 0;
        do
        begin
            ahb(1'h0, HOST_STAT_OFS, 32'h0, r);
            n++;
        end while ((r[0] !== 1'h0 || n < 2) && n < 400);
        if (n >= 400)
        begin
            n_fail++;
            stop_test;
        end
    endtask : send

    initial
    begin
        logic [31:0] r;
        repeat (10) @(posedge clk_sys);
        check("reset pins", vec, 12'h020);
        rst_n <= 1'h1;
        ahb(1'h0, HOST_CFG_OFS, 32'h0, r);
        check("cfg", r, {24'h0, HALF_RST});
        ahb(1'h1, HOST_CFG_OFS, 32'h6, r);
        ahb(1'h1, 8'h0C, 32'h5A, r);
        ahb(1'h0, 8'h0C, 32'h0, r);
        check("unmapped", r, 32'h0);
        ahb(1'h0, HOST_CFG_OFS, 32'h0, r);
        check("cfg", r, 32'h6);
        for (int i = 0; i < 13; i++)
        begin
            send(cmd_l[i]);
            check("pins", vec, {20'h0, exp_l[i]});
            if (i == 4)
                ahb(1'h1, HOST_CFG_OFS, 32'h106, r);
            if (i == 1 || i == 5)
            begin
                ahb(1'h0, HOST_STAT_OFS, 32'h0, r);
                check("readback", {r[15:13], r[11:8], r[0]}, 32'h16);
            end
            if (i == 3)
            begin
                ahb(1'h0, HOST_TX_OFS, 32'h0, r);
                check("tx", r, 32'hA1);
            end
        end
        for (int k = 1; k < 4; k++)
        begin
            send({4'h8, k[1:0], 2'h0});
            r = n_clk;
            repeat (128) @(posedge clk_sys);
            check("cclk", n_clk - r, 32'h20 >> k);
        end
        stop_test;
    end
endmodule : smart_card_spi_command_decoder_bench
`default_nettype wire
